// file: gpp_port_mux.sv
// Notes on behaviour
// - Port 1 pull-up acts only while that pin's direction bit is input.
// - Port 1 pull-up bits 7-4, 2-0 switch pull-ups; reset to 0.
// - Port 1 pull-up bit 3 reserved: reads 1, resets 1, ignores writes.
// - Select bits route pins 7 and 4 to interrupt/trigger inputs.
// - Direction 1 drives pin from latch; 0 makes it an input.
// - Port 2 data writes store pins 2-0 in a latch reset to 0.
// - Data read returns latch for outputs, live pin level for inputs.
// - Port 2 data bits 7 to 3 always read as 1.
// - Pin 2 becomes transmit output; pin 1 receive input when enabled.
// - Port 2 pin 0 serial clock selection from clock enables and mode.
// - Port 1 pin 2 uses same clock selection from third channel.
// - Function select bit 7 for pin 7, bit 4 for pin 4; reset 0.
// - Function select bit 1 routes serial transmit to port 2 pin 2.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
module gpp_port_mux #(
    parameter bit HAS_CHANNEL_C = 1'b1
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [gpp_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [gpp_pkg::DATA_W-1:0]   pwdata,
    output logic      [gpp_pkg::DATA_W-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic [gpp_pkg::REG_W-1:0]    port1_pin_in,
    output logic      [gpp_pkg::REG_W-1:0]    port1_pin_out,
    output logic      [gpp_pkg::REG_W-1:0]    port1_pin_oe,
    output logic      [gpp_pkg::REG_W-1:0]    port1_pullup_on,
    input  wire logic [gpp_pkg::REG_W-1:0]    port1_data_latch,
    input  wire logic [gpp_pkg::P2_PINS-1:0]  port2_pin_in,
    output logic      [gpp_pkg::P2_PINS-1:0]  port2_pin_out,
    output logic      [gpp_pkg::P2_PINS-1:0]  port2_pin_oe,
    output logic                              ext_intr_line_a,
    output logic                              ext_intr_line_b,
    output logic                              timer_trigger_in,
    input  wire logic                         serial_tx_data,
    output logic                              serial_rx_data,
    input  wire logic                         receiver_enable_bit,
    input  wire logic                         clock_enable_upper,
    input  wire logic                         clock_enable_lower,
    input  wire logic                         serial_sync_mode,
    input  wire logic                         serial_clk_drive,
    output logic                              serial_clock_pin_in,
    input  wire logic                         clock_enable_upper_c,
    input  wire logic                         clock_enable_lower_c,
    input  wire logic                         serial_sync_mode_c,
    input  wire logic                         serial_clk_drive_c,
    output logic                              serial_clock_pin_ch_c_in
);
    import gpp_pkg::*;

    // ========================================================================
    // Register state
    logic [REG_W-1:0]   pin_function_select_ff;
    logic [REG_W-1:0]   nxt_pin_function_select;

    logic [REG_W-1:0]   port1_direction_ff;
    logic [REG_W-1:0]   nxt_port1_direction;

    logic [REG_W-1:0]   port1_pullup_enable_ff;
    logic [REG_W-1:0]   nxt_port1_pullup_enable;

    logic [P2_PINS-1:0] port2_direction_ff;
    logic [P2_PINS-1:0] nxt_port2_direction;

    logic [P2_PINS-1:0] port2_output_latch_ff;
    logic [P2_PINS-1:0] nxt_port2_output_latch;

    logic [DATA_W-1:0]  nxt_prdata;
    logic               nxt_pready;
    logic               nxt_pslverr;

    // ========================================================================
    // Synchronised pins and combinational pin results
    logic [REG_W-1:0]   p1_sync;
    logic [P2_PINS-1:0] p2_sync;

    logic [REG_W-1:0]   p2_read;
    logic [REG_W-1:0]   wdata8;
    logic               access;
    logic               commit;

    logic [REG_W-1:0]   nxt_p1_out;
    logic [REG_W-1:0]   nxt_p1_oe;
    logic [REG_W-1:0]   nxt_p1_pullup;

    logic [P2_PINS-1:0] nxt_p2_out;
    logic [P2_PINS-1:0] nxt_p2_oe;

    logic               nxt_irq_a;
    logic               nxt_irq_b;
    logic               nxt_trig;
    logic               nxt_rx;

    logic               clk_oe;
    logic               clk_out;
    logic               clk_in;

    logic               clk_c_oe;
    logic               clk_c_out;
    logic               clk_c_in;

    // Pin levels are asynchronous to pclk, so two flip-flops stand before any
    // logic; a read-back therefore lags the pin by the synchroniser's edges.
    gpp_sync2 #(.W(REG_W)) u_sync_p1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (port1_pin_in),
        .sync_out (p1_sync)
    );

    gpp_sync2 #(.W(P2_PINS)) u_sync_p2 (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (port2_pin_in),
        .sync_out (p2_sync)
    );

    gpp_clk_pin_sel #(.HAS_CHANNEL(1'b1)) u_clk_p2 (
        .clock_enable_upper (clock_enable_upper),
        .clock_enable_lower (clock_enable_lower),
        .sync_mode          (serial_sync_mode),
        .dir                (port2_direction_ff[P2_CLK_PIN]),
        .latch              (port2_output_latch_ff[P2_CLK_PIN]),
        .clk_drive          (serial_clk_drive),
        .pin_level          (p2_sync[P2_CLK_PIN]),
        .pin_oe             (clk_oe),
        .pin_out            (clk_out),
        .clk_in             (clk_in)
    );

    // Variants without the third channel set the parameter to 0, which
    // leaves port 1 pin 2 as plain I/O under its direction bit.
    gpp_clk_pin_sel #(.HAS_CHANNEL(HAS_CHANNEL_C)) u_clk_p1 (
        .clock_enable_upper (clock_enable_upper_c),
        .clock_enable_lower (clock_enable_lower_c),
        .sync_mode          (serial_sync_mode_c),
        .dir                (port1_direction_ff[P1_CLK_PIN]),
        .latch              (port1_data_latch[P1_CLK_PIN]),
        .clk_drive          (serial_clk_drive_c),
        .pin_level          (p1_sync[P1_CLK_PIN]),
        .pin_oe             (clk_c_oe),
        .pin_out            (clk_c_out),
        .clk_in             (clk_c_in)
    );

    // ========================================================================
    // Port 2 data read-back: latch for outputs, pin level for inputs.
    always_comb begin
        p2_read = P2_LATCH_FIXED;
        for (int i = 0; i < P2_PINS; i++) begin
            p2_read[i] = port2_direction_ff[i] ? port2_output_latch_ff[i]
                                               : p2_sync[i];
        end
    end

    // ========================================================================
    // APB slave. The access phase lasts two cycles so that read data and
    // the error flag can come from flip-flops; writes land on the edge
    // where pready is sampled high.
    assign wdata8 = pwdata[REG_W-1:0];
    assign access = psel && penable && !pready;
    assign commit = psel && penable && pready && pwrite;

    always_comb begin
        nxt_pin_function_select = pin_function_select_ff;
        nxt_port1_direction     = port1_direction_ff;
        nxt_port1_pullup_enable = port1_pullup_enable_ff;
        nxt_port2_direction     = port2_direction_ff;
        nxt_port2_output_latch  = port2_output_latch_ff;
        nxt_pready              = access;
        nxt_prdata              = RDATA_IDLE;
        nxt_pslverr             = 1'b0;

        if (access) begin
            if (paddr == OFS_PIN_FUNC) begin
                nxt_prdata[REG_W-1:0] = pin_function_select_ff;
            end else if (paddr == OFS_P1_DIR) begin
                nxt_prdata[REG_W-1:0] = DIR_READ_VALUE;
            end else if (paddr == OFS_P1_PULLUP) begin
                nxt_prdata[REG_W-1:0] = port1_pullup_enable_ff
                                      | P1_PULLUP_FIXED;
            end else if (paddr == OFS_P2_DIR) begin
                nxt_prdata[REG_W-1:0] = DIR_READ_VALUE;
            end else if (paddr == OFS_P2_LATCH) begin
                nxt_prdata[REG_W-1:0] = p2_read;
            end else begin
                nxt_pslverr = 1'b1;
            end
        end

        if (commit) begin
            if (paddr == OFS_PIN_FUNC) begin
                nxt_pin_function_select = wdata8 & PIN_FUNC_WMASK;
            end else if (paddr == OFS_P1_DIR) begin
                nxt_port1_direction = wdata8 & P1_DIR_WMASK;
            end else if (paddr == OFS_P1_PULLUP) begin
                nxt_port1_pullup_enable = (wdata8 & P1_PULLUP_WMASK)
                                        | P1_PULLUP_FIXED;
            end else if (paddr == OFS_P2_DIR) begin
                nxt_port2_direction = wdata8[P2_PINS-1:0];
            end else if (paddr == OFS_P2_LATCH) begin
                nxt_port2_output_latch = wdata8[P2_PINS-1:0];
            end
        end
    end

    // ========================================================================
    // Port 1 pin functions
    always_comb begin
        nxt_p1_out = port1_data_latch;
        nxt_p1_oe  = port1_direction_ff;
        nxt_p1_oe[P1_CLK_PIN]  = clk_c_oe;
        nxt_p1_out[P1_CLK_PIN] = clk_c_out;
        // Pull-ups are gated by direction only, so a pin taken by a
        // peripheral input keeps its pull-up while its direction is 0.
        nxt_p1_pullup = port1_pullup_enable_ff & ~port1_direction_ff
                      & P1_PULLUP_WMASK;
        nxt_irq_b = IRQ_IDLE;
        nxt_trig  = IRQ_IDLE;
        nxt_irq_a = IRQ_IDLE;
        if (pin_function_select_ff[FUNC_IRQ_B_BIT]) begin
            nxt_p1_oe[P1_IRQ_B_PIN] = 1'b0;
            nxt_irq_b = p1_sync[P1_IRQ_B_PIN];
            nxt_trig  = p1_sync[P1_IRQ_B_PIN];
        end
        if (pin_function_select_ff[FUNC_IRQ_A_BIT]) begin
            nxt_p1_oe[P1_IRQ_A_PIN] = 1'b0;
            nxt_irq_a = p1_sync[P1_IRQ_A_PIN];
        end
    end

    // ========================================================================
    // Port 2 pin functions
    always_comb begin
        nxt_p2_out = port2_output_latch_ff;
        nxt_p2_oe  = port2_direction_ff;
        nxt_rx     = RX_IDLE;
        if (pin_function_select_ff[FUNC_TX_BIT]) begin
            nxt_p2_oe[P2_TX_PIN]  = 1'b1;
            nxt_p2_out[P2_TX_PIN] = serial_tx_data;
        end
        if (receiver_enable_bit) begin
            nxt_p2_oe[P2_RX_PIN] = 1'b0;
            nxt_rx = p2_sync[P2_RX_PIN];
        end
        nxt_p2_oe[P2_CLK_PIN]  = clk_oe;
        nxt_p2_out[P2_CLK_PIN] = clk_out;
    end

    // ========================================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_function_select_ff   <= PIN_FUNC_RST;
            port1_direction_ff       <= P1_DIR_RST;
            port1_pullup_enable_ff   <= P1_PULLUP_RST;
            port2_direction_ff       <= P2_DIR_RST;
            port2_output_latch_ff    <= P2_LATCH_RST;

            prdata                   <= RDATA_IDLE;
            pready                   <= 1'b0;
            pslverr                  <= 1'b0;

            port1_pin_out            <= '0;
            port1_pin_oe             <= '0;
            port1_pullup_on          <= '0;
            port2_pin_out            <= '0;
            port2_pin_oe             <= '0;
            ext_intr_line_a          <= IRQ_IDLE;
            ext_intr_line_b          <= IRQ_IDLE;
            timer_trigger_in         <= IRQ_IDLE;
            serial_rx_data           <= RX_IDLE;
            serial_clock_pin_in      <= CLK_IN_IDLE;
            serial_clock_pin_ch_c_in <= CLK_IN_IDLE;
        end else begin
            pin_function_select_ff   <= nxt_pin_function_select;
            port1_direction_ff       <= nxt_port1_direction;
            port1_pullup_enable_ff   <= nxt_port1_pullup_enable;
            port2_direction_ff       <= nxt_port2_direction;
            port2_output_latch_ff    <= nxt_port2_output_latch;

            prdata                   <= nxt_prdata;
            pready                   <= nxt_pready;
            pslverr                  <= nxt_pslverr;

            port1_pin_out            <= nxt_p1_out;
            port1_pin_oe             <= nxt_p1_oe;
            port1_pullup_on          <= nxt_p1_pullup;
            port2_pin_out            <= nxt_p2_out;
            port2_pin_oe             <= nxt_p2_oe;
            ext_intr_line_a          <= nxt_irq_a;
            ext_intr_line_b          <= nxt_irq_b;
            timer_trigger_in         <= nxt_trig;
            serial_rx_data           <= nxt_rx;
            serial_clock_pin_in      <= clk_in;
            serial_clock_pin_ch_c_in <= clk_c_in;
        end
    end

endmodule : gpp_port_mux

// file: gpp_pkg.sv
package gpp_pkg;

    // ========================================================================
    // Bus geometry
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          REG_W           = 8;
    localparam int          SYNC_STAGES     = 2;

    // ========================================================================
    // Register byte offsets
    localparam logic [7:0]  OFS_PIN_FUNC    = 8'h00;
    localparam logic [7:0]  OFS_P1_DIR      = 8'h04;
    localparam logic [7:0]  OFS_P1_PULLUP   = 8'h08;
    localparam logic [7:0]  OFS_P2_DIR      = 8'h0c;
    localparam logic [7:0]  OFS_P2_LATCH    = 8'h10;

    // ========================================================================
    // Reset values, writable masks and fixed read bits
    localparam logic [7:0]  PIN_FUNC_RST    = 8'h00;
    localparam logic [7:0]  PIN_FUNC_WMASK  = 8'h9e;
    localparam logic [7:0]  P1_DIR_RST      = 8'h00;
    localparam logic [7:0]  P1_DIR_WMASK    = 8'hf7;
    localparam logic [7:0]  P1_PULLUP_RST   = 8'h08;
    localparam logic [7:0]  P1_PULLUP_WMASK = 8'hf7;
    localparam logic [7:0]  P1_PULLUP_FIXED = 8'h08;
    localparam logic [2:0]  P2_DIR_RST      = 3'h0;
    localparam logic [2:0]  P2_LATCH_RST    = 3'h0;
    localparam logic [7:0]  P2_LATCH_FIXED  = 8'hf8;
    localparam logic [7:0]  DIR_READ_VALUE  = 8'h00;
    localparam logic [31:0] RDATA_IDLE      = 32'h0000_0000;

    // ========================================================================
    // Field and pin positions
    localparam int          FUNC_IRQ_B_BIT  = 7;
    localparam int          FUNC_IRQ_A_BIT  = 4;
    localparam int          FUNC_TX_BIT     = 1;
    localparam int          P1_IRQ_B_PIN    = 7;
    localparam int          P1_IRQ_A_PIN    = 4;
    localparam int          P1_CLK_PIN      = 2;
    localparam int          P2_PINS         = 3;
    localparam int          P2_TX_PIN       = 2;
    localparam int          P2_RX_PIN       = 1;
    localparam int          P2_CLK_PIN      = 0;

    // ========================================================================
    // Idle levels of signals handed to peripherals
    localparam logic        IRQ_IDLE        = 1'b1;
    localparam logic        RX_IDLE         = 1'b1;
    localparam logic        CLK_IN_IDLE     = 1'b0;

endpackage : gpp_pkg

// file: gpp_sync2.sv
module gpp_sync2 #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    import gpp_pkg::*;

    // ========================================================================
    // Two-stage synchroniser; the first stage feeds only the second.
    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= nxt_meta;
            sync_out <= nxt_sync;
        end
    end

endmodule : gpp_sync2

// file: gpp_clk_pin_sel.sv
module gpp_clk_pin_sel #(
    parameter bit HAS_CHANNEL = 1'b1
) (
    input  wire logic clock_enable_upper,
    input  wire logic clock_enable_lower,
    input  wire logic sync_mode,
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic clk_drive,
    input  wire logic pin_level,
    output logic      pin_oe,
    output logic      pin_out,
    output logic      clk_in
);
    import gpp_pkg::*;

    // ========================================================================
    // Serial clock pin selection; serial settings override direction.
    always_comb begin
        pin_oe  = dir;
        pin_out = latch;
        clk_in  = CLK_IN_IDLE;
        if (!HAS_CHANNEL) begin
            pin_oe  = dir;
        end else if (clock_enable_upper) begin
            pin_oe  = 1'b0;
            clk_in  = pin_level;
        end else if (clock_enable_lower || sync_mode) begin
            pin_oe  = 1'b1;
            pin_out = clk_drive;
        end
    end

endmodule : gpp_clk_pin_sel

// file: gpp_monitor.sv
// ==========================================================
// Port checks of the pin mux block.
module gpp_monitor (
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          pwrite,
    input wire logic [gpp_pkg::ADDR_W-1:0]    paddr,
    input wire logic [gpp_pkg::DATA_W-1:0]    prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire logic [gpp_pkg::REG_W-1:0]     port1_pin_oe,
    input wire logic [gpp_pkg::REG_W-1:0]     port1_pullup_on,
    input wire logic [gpp_pkg::P2_PINS-1:0]   port2_pin_oe,
    input wire logic [gpp_pkg::P2_PINS-1:0]   port2_pin_out,
    input wire logic                          ext_intr_line_b,
    input wire logic                          serial_rx_data,
    input wire logic                          clock_enable_upper,
    input wire logic                          clock_enable_lower,
    input wire logic                          serial_sync_mode,
    input wire logic                          serial_clk_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpp_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // The clock pin is left out: a clock output may keep its pull-up bit.
    property p_pu_dir;
        (port1_pullup_on & port1_pin_oe & 8'hfb) == 8'h00;
    endproperty
    a_pu_dir: assert property (p_pu_dir) else $error("pullup on out");
    property p_pu_read;
        pready && !pwrite && !pslverr && paddr == OFS_P1_PULLUP |-> prdata[3];
    endproperty
    a_pu_read: assert property (p_pu_read) else $error("bit3 low");
    property p_p2_rsv;
        pready && !pwrite && paddr == OFS_P2_LATCH |-> prdata[31:3] == 29'h1f;
    endproperty
    a_p2_rsv: assert property (p_p2_rsv) else $error("p2 high bits");
    property p_dir_read;
        pready && !pwrite && (paddr == OFS_P1_DIR || paddr == OFS_P2_DIR)
            |-> prdata == {24'h0, DIR_READ_VALUE};
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("dir read");
    property p_irq_in;
        !ext_intr_line_b |-> !port1_pin_oe[7];
    endproperty
    a_irq_in: assert property (p_irq_in) else $error("irq pin driven");
    property p_rx_in;
        !serial_rx_data |-> !port2_pin_oe[1];
    endproperty
    a_rx_in: assert property (p_rx_in) else $error("rx pin driven");
    property p_clk_in;
        clock_enable_upper |=> !port2_pin_oe[0];
    endproperty
    a_clk_in: assert property (p_clk_in) else $error("clk in driven");
    property p_clk_out;
        !clock_enable_upper && (clock_enable_lower || serial_sync_mode)
            |=> port2_pin_oe[0] && port2_pin_out[0] == $past(serial_clk_drive);
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("clk out");
endmodule : gpp_monitor

// file: gpp_pin_model.sv
// ==========================================================
// Far side: pins with optional outside drivers.
module gpp_pin_model (
    input  wire logic       pclk,
    input  wire logic [7:0] port1_pin_out,
    input  wire logic [7:0] port1_pin_oe,
    input  wire logic [7:0] port1_pullup_on,
    input  wire logic [2:0] port2_pin_out,
    input  wire logic [2:0] port2_pin_oe,
    input  wire logic [7:0] ext1_en,
    input  wire logic [7:0] ext1_val,
    input  wire logic [2:0] ext2_en,
    input  wire logic [2:0] ext2_val,
    output logic      [7:0] port1_pin_in,
    output logic      [2:0] port2_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip_ff = 1'b0;
    // A floating pin wanders, so an unpulled input never reads steady.
    always @(posedge pclk) begin
        flip_ff <= ~flip_ff;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            port1_pin_in[i] = port1_pin_oe[i] ? port1_pin_out[i] :
                ext1_en[i] ? ext1_val[i] :
                port1_pullup_on[i] ? 1'b1 : flip_ff;
        end
        for (int i = 0; i < 3; i++) begin
            port2_pin_in[i] = port2_pin_oe[i] ? port2_pin_out[i] :
                ext2_en[i] ? ext2_val[i] : flip_ff;
        end
    end
endmodule : gpp_pin_model

// file: tb.sv
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end

// ==========================================================
// Bench for the pin mux block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpp_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, last_err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0]  port1_pin_in, port1_pin_out, port1_pin_oe, port1_pullup_on;
    logic [7:0]  port1_data_latch = 8'h5a, ext1_en = 8'h00, ext1_val = 8'h00;
    logic [2:0]  port2_pin_in, port2_pin_out, port2_pin_oe;
    logic [2:0]  ext2_en = 3'h0, ext2_val = 3'h0;
    logic        ext_intr_line_a, ext_intr_line_b, timer_trigger_in;
    logic        serial_rx_data, serial_clock_pin_in, serial_clock_pin_ch_c_in;
    logic        serial_tx_data = 1'b1, receiver_enable_bit = 1'b0;
    logic        clock_enable_upper = 1'b0, clock_enable_lower = 1'b0;
    logic        serial_sync_mode = 1'b0, serial_clk_drive = 1'b0;
    logic        clock_enable_upper_c = 1'b0, clock_enable_lower_c = 1'b0;
    logic        serial_sync_mode_c = 1'b0, serial_clk_drive_c = 1'b1;
    int          err_count = 0, num_checks = 0;

    gpp_port_mux dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port1_pin_in, .port1_pin_out, .port1_pin_oe,
        .port1_pullup_on, .port1_data_latch, .port2_pin_in, .port2_pin_out,
        .port2_pin_oe, .ext_intr_line_a, .ext_intr_line_b, .timer_trigger_in,
        .serial_tx_data, .serial_rx_data, .receiver_enable_bit,
        .clock_enable_upper, .clock_enable_lower, .serial_sync_mode,
        .serial_clk_drive, .serial_clock_pin_in, .clock_enable_upper_c,
        .clock_enable_lower_c, .serial_sync_mode_c, .serial_clk_drive_c,
        .serial_clock_pin_ch_c_in
    );
    gpp_pin_model u_pins (
        .pclk, .port1_pin_out, .port1_pin_oe, .port1_pullup_on, .port2_pin_out,
        .port2_pin_oe, .ext1_en, .ext1_val, .ext2_en, .ext2_val,
        .port1_pin_in, .port2_pin_in
    );
    always #2 pclk = ~pclk;

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 8'h00, r);
        `CHK(r, exp);
    endtask : rd_chk
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : tick
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic t_pullup();
        rd_chk(OFS_P1_PULLUP, 32'h08);
        rd_chk(OFS_PIN_FUNC, 32'h00);
        rd_chk(OFS_P1_DIR, 32'h00);
        wr(OFS_P1_PULLUP, 8'hff);
        rd_chk(OFS_P1_PULLUP, 32'hff);
        rd_chk(8'h40, 32'h00);
        `CHK(last_err, 1'b1);
        wr(OFS_P1_PULLUP, 8'ha5);
        tick(2);
        `CHK(port1_pullup_on, 8'ha5);
        wr(OFS_P1_DIR, 8'h0f);
        tick(2);
        `CHK(port1_pullup_on, 8'ha0);
        `CHK({port1_pin_oe, port1_pin_out & 8'h07}, 16'h0702);
        wr(OFS_P1_PULLUP, 8'h00);
        rd_chk(OFS_P1_PULLUP, 32'h08);
    endtask : t_pullup
    task automatic t_port2();
        wr(OFS_P2_DIR, 8'h07);
        tick(2);
        `CHK({port2_pin_oe, port2_pin_out}, 6'h38);
        wr(OFS_P2_LATCH, 8'h05);
        tick(2);
        `CHK(port2_pin_out, 3'h5);
        rd_chk(OFS_P2_LATCH, 32'hfd);
        rd_chk(OFS_P2_DIR, 32'h00);
        `CHK(port2_pin_oe, 3'h7);
        wr(OFS_P2_DIR, 8'h00);
        ext2_en <= 3'h7;
        ext2_val <= 3'h2;
        tick(4);
        rd_chk(OFS_P2_LATCH, 32'hfa);
    endtask : t_port2
    task automatic t_func();
        wr(OFS_P1_DIR, 8'h90);
        wr(OFS_PIN_FUNC, 8'hff);
        rd_chk(OFS_PIN_FUNC, 32'h9e);
        ext1_en <= 8'h90;
        serial_tx_data <= 1'b0;
        tick(4);
        `CHK({ext_intr_line_b, timer_trigger_in, ext_intr_line_a}, 3'h0);
        `CHK(port1_pin_oe & 8'h90, 8'h00);
        `CHK({port2_pin_oe[2], port2_pin_out[2]}, 2'b10);
        wr(OFS_PIN_FUNC, 8'h00);
        tick(4);
        `CHK({ext_intr_line_b, timer_trigger_in, ext_intr_line_a}, 3'h7);
        `CHK({port1_pin_oe & 8'h90, port2_pin_oe[2]}, 9'h120);
    endtask : t_func
    task automatic t_serial();
        logic [2:0] modes [4] = '{3'b000, 3'b001, 3'b010, 3'b100};
        wr(OFS_P2_DIR, 8'h07);
        wr(OFS_P1_DIR, 8'h04);
        ext1_en <= 8'h04;
        ext1_val <= 8'h04;
        ext2_val <= 3'h5;
        receiver_enable_bit <= 1'b1;
        tick(4);
        `CHK({serial_rx_data, port2_pin_oe}, 4'h5);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            {clock_enable_upper, clock_enable_lower, serial_sync_mode}
                <= modes[i];
            {clock_enable_upper_c, clock_enable_lower_c, serial_sync_mode_c}
                <= modes[i];
            tick(4);
            `CHK({port2_pin_oe[0], serial_clock_pin_in}, {i < 3, i == 3});
            `CHK({port1_pin_oe[2], serial_clock_pin_ch_c_in}, {i < 3, i == 3});
            if (i < 3) begin
                `CHK({port2_pin_out[0], port1_pin_out[2]}, {i == 0, i != 0});
            end
        end
    endtask : t_serial

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_pullup();
        t_port2();
        t_func();
        t_serial();
        stop_test();
    end
    // Far longer than the whole sequence needs, so only a hang trips it.
    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        stop_test();
    end
endmodule : tb

bind gpp_port_mux gpp_monitor u_mon (
    .pclk, .presetn, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .port1_pin_oe, .port1_pullup_on, .port2_pin_oe, .port2_pin_out,
    .ext_intr_line_b, .serial_rx_data, .clock_enable_upper,
    .clock_enable_lower, .serial_sync_mode, .serial_clk_drive
);
